//--- logic/mld_regs.sv
// debug control and gain readback registers for the motor loop core
`timescale 1ns/100ps
`include "mld_params.svh"

// Summary of operation
// - bypass bit 26 disables current and speed loops
// - bypass takes direct ref from bits 25-16
// - code up to 500 over 500, codes 501-512 clamp to 500, codes above 512 offset 1024
// - bypass takes quadrature ref from bits 15-6
// - quadrature codes scaled like direct; software limits range
// - writing start bit 5 in idle launches measurement routine
// - bit 4 selects resistance measurement
// - bit 3 selects inductance measurement
// - bit 2 selects back-emf constant measurement
// - bit 1 selects mechanical measurement
// - writing bit 0 copies results to shadow
// - readback bits 31-16 show integral gain
// - readback bits 15-0 show proportional gain
module mld_regs #(
    parameter int GAIN_W = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access port
    input wire mld_pkg::mld_req_type reg_req,
    output logic [31:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    // inner loop controller side
    input wire logic signed [15:0] loop_direct_ref,
    input wire logic signed [15:0] loop_quad_ref,
    input wire logic [GAIN_W-1:0] integral_gain,
    input wire logic [GAIN_W-1:0] prop_gain,
    output logic inner_loop_bypass_ff,
    output logic loops_disabled_ff,
    output logic signed [15:0] direct_axis_voltage_ref_ff,
    output logic signed [15:0] quadrature_axis_voltage_ref_ff,
    // parameter measurement side
    input wire logic measure_done,
    output logic measure_start_ff,
    output logic measure_busy_ff,
    output mld_pkg::mld_sel_type measure_sel_ff,
    output logic measured_to_shadow_ff
);
    import mld_pkg::*;

    // elaboration check: gain must fit its 16-bit field
    if (GAIN_W < 1 || GAIN_W > 16) begin : g_bad_gain_w
        $error("mld_regs: GAIN_W must be 1 to 16");
    end

    // code to signed reference, 1.0 = REF_ONE
    function automatic logic signed [15:0] to_ref(input logic [9:0] code);
        logic signed [31:0] num;
        logic signed [31:0] scaled;
        num = 32'sd0;
        scaled = 32'sd0;
        if (code > 10'(`MLD_CODE_NEG_MIN)) begin
            num = $signed({22'h0, code}) - `MLD_SCALE_OFFS;
        end else if (code > 10'(`MLD_SCALE_DIV)) begin
            num = `MLD_SCALE_DIV;
        end else begin
            num = $signed({22'h0, code});
        end
        scaled = (num * `MLD_REF_ONE) / `MLD_SCALE_DIV;
        return scaled[15:0];
    endfunction

    mld_ctrl_type ctrl_ff;
    mld_ctrl_type nxt_ctrl;
    mld_state_type state_ff;
    mld_state_type nxt_state;
    logic nxt_busy;
    logic [31:0] nxt_rdata;
    logic signed [15:0] nxt_direct;
    logic signed [15:0] nxt_quad;
    mld_sel_type nxt_sel;

    // address decode
    wire logic hit_ctrl = (reg_req.addr == `MLD_OFS_CTRL);
    wire logic hit_gain = (reg_req.addr == `MLD_OFS_GAIN);
    wire logic wr_ctrl = reg_req.wr && hit_ctrl;
    wire logic rd_any = reg_req.rd;
    wire logic start_req = wr_ctrl && reg_req.wdata[`MLD_BIT_START];
    wire logic start_take = start_req && (state_ff == MLD_IDLE);
    wire logic shadow_req = wr_ctrl && reg_req.wdata[`MLD_BIT_SHADOW];
    wire logic [31:0] wd = reg_req.wdata;

    // control register next value; bits 31-27 never stored
    assign nxt_ctrl.bypass = wr_ctrl ? wd[`MLD_BIT_BYPASS] : ctrl_ff.bypass;
    assign nxt_ctrl.vd = wr_ctrl ? wd[`MLD_VD_HI:`MLD_VD_LO] : ctrl_ff.vd;
    assign nxt_ctrl.vq = wr_ctrl ? wd[`MLD_VQ_HI:`MLD_VQ_LO] : ctrl_ff.vq;
    assign nxt_ctrl.sel = wr_ctrl ? {wd[`MLD_BIT_RES], wd[`MLD_BIT_IND], wd[`MLD_BIT_BEMF],
                                     wd[`MLD_BIT_MECH]} : ctrl_ff.sel;

    // selections latched only when a routine is launched
    assign nxt_sel = start_take ? {wd[`MLD_BIT_RES], wd[`MLD_BIT_IND], wd[`MLD_BIT_BEMF],
                                   wd[`MLD_BIT_MECH]} : measure_sel_ff;

    // voltage reference source select
    assign nxt_direct = nxt_ctrl.bypass ? to_ref(nxt_ctrl.vd) : loop_direct_ref;
    assign nxt_quad = nxt_ctrl.bypass ? to_ref(nxt_ctrl.vq) : loop_quad_ref;

    // measurement sequencer: start in idle, done ends it
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MLD_IDLE: begin
                if (start_take) begin
                    nxt_state = MLD_RUN;
                end
            end
            MLD_RUN: begin
                if (measure_done) begin
                    nxt_state = MLD_IDLE;
                end
            end
            default: begin
                nxt_state = MLD_IDLE;
            end
        endcase
    end
    assign nxt_busy = (nxt_state == MLD_RUN);

    // read data mux; command bits read zero, reserved read zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (hit_ctrl) begin
            nxt_rdata[`MLD_BIT_BYPASS] = ctrl_ff.bypass;
            nxt_rdata[`MLD_VD_HI:`MLD_VD_LO] = ctrl_ff.vd;
            nxt_rdata[`MLD_VQ_HI:`MLD_VQ_LO] = ctrl_ff.vq;
            nxt_rdata[`MLD_BIT_RES] = ctrl_ff.sel[3];
            nxt_rdata[`MLD_BIT_IND] = ctrl_ff.sel[2];
            nxt_rdata[`MLD_BIT_BEMF] = ctrl_ff.sel[1];
            nxt_rdata[`MLD_BIT_MECH] = ctrl_ff.sel[0];
        end else if (hit_gain) begin
            nxt_rdata[`MLD_KI_LO +: GAIN_W] = integral_gain;
            nxt_rdata[`MLD_KP_LO +: GAIN_W] = prop_gain;
        end
    end

    // control storage and sequencer state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= mld_ctrl_type'(25'h0000000);
            state_ff <= MLD_IDLE;
            measure_sel_ff <= 4'h0;
            measure_busy_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            state_ff <= nxt_state;
            measure_sel_ff <= nxt_sel;
            measure_busy_ff <= nxt_busy;
        end
    end

    // command pulses and loop outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            measure_start_ff <= 1'b0;
            measured_to_shadow_ff <= 1'b0;
            inner_loop_bypass_ff <= 1'b0;
            loops_disabled_ff <= 1'b0;
        end else begin
            measure_start_ff <= start_take;
            measured_to_shadow_ff <= shadow_req;
            inner_loop_bypass_ff <= nxt_ctrl.bypass;
            loops_disabled_ff <= nxt_ctrl.bypass;
        end
    end

    // references and read answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            direct_axis_voltage_ref_ff <= 16'sh0000;
            quadrature_axis_voltage_ref_ff <= 16'sh0000;
            reg_rdata_ff <= `MLD_GAIN_RESET;
            reg_rvalid_ff <= 1'b0;
        end else begin
            direct_axis_voltage_ref_ff <= nxt_direct;
            quadrature_axis_voltage_ref_ff <= nxt_quad;
            reg_rdata_ff <= rd_any ? nxt_rdata : 32'h00000000;
            reg_rvalid_ff <= rd_any;
        end
    end

    // checks on the bank's own outputs
    chk_bypass_follow: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ctrl |=> (inner_loop_bypass_ff == $past(wd[`MLD_BIT_BYPASS]))
            && (loops_disabled_ff == inner_loop_bypass_ff))
        else $error("bypass output does not follow written bit");

    chk_vd_scale_pos: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && wd[`MLD_BIT_BYPASS] && wd[`MLD_VD_HI:`MLD_VD_LO] == 10'h1F4)
            |=> direct_axis_voltage_ref_ff == 16'sh4000)
        else $error("direct code 500 not full scale");

    chk_vd_scale_neg: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && wd[`MLD_BIT_BYPASS] && wd[`MLD_VD_HI:`MLD_VD_LO] == 10'h20C)
            |=> direct_axis_voltage_ref_ff == -16'sh4000)
        else $error("direct code 524 not negative full scale");

    chk_vq_scale_mid: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && wd[`MLD_BIT_BYPASS] && wd[`MLD_VQ_HI:`MLD_VQ_LO] == 10'h0FA)
            |=> quadrature_axis_voltage_ref_ff == 16'sh2000)
        else $error("quadrature code 250 not half scale");

    chk_loop_pass: assert property (@(posedge clk) disable iff (!rst_n)
        (!nxt_ctrl.bypass) |=> direct_axis_voltage_ref_ff == $past(loop_direct_ref))
        else $error("loop reference not passed with bypass off");

    chk_start_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (start_req && state_ff == MLD_IDLE) |=> measure_start_ff && measure_busy_ff ##1 !measure_start_ff)
        else $error("start write did not give one start pulse");

    chk_sel_capture: assert property (@(posedge clk) disable iff (!rst_n)
        start_take |=> measure_sel_ff == {$past(wd[4]), $past(wd[3]), $past(wd[2]), $past(wd[1])})
        else $error("measurement selection not captured at start");

    chk_sel_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (measure_busy_ff && $past(measure_busy_ff)) |-> $stable(measure_sel_ff))
        else $error("selection changed during routine");

    chk_shadow_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        shadow_req |=> measured_to_shadow_ff)
        else $error("shadow copy not requested");

    chk_gain_read: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_any && hit_gain) |=> reg_rvalid_ff && reg_rdata_ff[`MLD_KI_LO +: GAIN_W] == $past(integral_gain)
            && reg_rdata_ff[`MLD_KP_LO +: GAIN_W] == $past(prop_gain))
        else $error("gain readback wrong");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_any && hit_ctrl) |=> reg_rdata_ff[31:27] == 5'h00)
        else $error("reserved control bits not zero");

    // read answer stands one cycle, then falls back to zero
    chk_idle_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (!rd_any) |=> !reg_rvalid_ff && reg_rdata_ff == 32'h00000000)
        else $error("read answer outlived its strobe");

    chk_ctrl_readback: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_any && hit_ctrl) |=> reg_rdata_ff[`MLD_BIT_BYPASS] == $past(ctrl_ff.bypass)
            && reg_rdata_ff[`MLD_VD_HI:`MLD_VD_LO] == $past(ctrl_ff.vd)
            && reg_rdata_ff[`MLD_VQ_HI:`MLD_VQ_LO] == $past(ctrl_ff.vq))
        else $error("control readback wrong");

    chk_sel_readback: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_any && hit_ctrl) |=> reg_rdata_ff[`MLD_BIT_RES:`MLD_BIT_MECH] == $past(ctrl_ff.sel))
        else $error("stored selection readback wrong");

    // command bits self-clear, so software never sees them set
    chk_cmd_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_any && hit_ctrl) |=> !reg_rdata_ff[`MLD_BIT_START] && !reg_rdata_ff[`MLD_BIT_SHADOW])
        else $error("command bits read back set");

    // loop side and forced side of the reference select
    chk_quad_loop_pass: assert property (@(posedge clk) disable iff (!rst_n)
        (!nxt_ctrl.bypass) |=> quadrature_axis_voltage_ref_ff == $past(loop_quad_ref))
        else $error("quadrature loop reference not passed with bypass off");

    chk_forced_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_ff.bypass && !wr_ctrl) |=> $stable(direct_axis_voltage_ref_ff)
            && $stable(quadrature_axis_voltage_ref_ff))
        else $error("forced reference moved without a write");

    chk_bypass_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (!wr_ctrl) |=> $stable(inner_loop_bypass_ff))
        else $error("bypass changed without a control write");

    chk_loops_match: assert property (@(posedge clk) disable iff (!rst_n)
        loops_disabled_ff == inner_loop_bypass_ff)
        else $error("loop disable and bypass outputs differ");

    chk_vd_scale_far: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && wd[`MLD_BIT_BYPASS] && wd[`MLD_VD_HI:`MLD_VD_LO] == 10'h3E8)
            |=> direct_axis_voltage_ref_ff == -16'sh0312)
        else $error("direct code 1000 scaled wrong");

    chk_vq_scale_neg: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && wd[`MLD_BIT_BYPASS] && wd[`MLD_VQ_HI:`MLD_VQ_LO] == 10'h201)
            |=> quadrature_axis_voltage_ref_ff == -16'sh4168)
        else $error("quadrature code 513 scaled wrong");

    // sequencer: one pulse per accepted start, refused while running
    chk_no_stray_start: assert property (@(posedge clk) disable iff (!rst_n)
        (!start_take) |=> !measure_start_ff)
        else $error("start pulse without accepted start");

    chk_start_refused: assert property (@(posedge clk) disable iff (!rst_n)
        (start_req && state_ff == MLD_RUN) |=> !measure_start_ff && $stable(measure_sel_ff))
        else $error("start accepted while routine running");

    chk_busy_end: assert property (@(posedge clk) disable iff (!rst_n)
        (measure_busy_ff && measure_done) |=> !measure_busy_ff)
        else $error("busy did not fall after done");

    chk_state_onehot: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot(state_ff))
        else $error("sequencer state not one-hot");

    chk_shadow_single: assert property (@(posedge clk) disable iff (!rst_n)
        (!shadow_req) |=> !measured_to_shadow_ff)
        else $error("shadow pulse without shadow write");

    // main scenarios
    cov_bypass_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(inner_loop_bypass_ff));
    cov_routine: cover property (@(posedge clk) disable iff (!rst_n) measure_start_ff ##[1:20] !measure_busy_ff);
    cov_start_busy: cover property (@(posedge clk) disable iff (!rst_n) start_req && state_ff == MLD_RUN);
    cov_gain_read: cover property (@(posedge clk) disable iff (!rst_n) rd_any && hit_gain);
    cov_shadow_busy: cover property (@(posedge clk) disable iff (!rst_n) measured_to_shadow_ff && measure_busy_ff);

endmodule // mld_regs

//--- inc/mld_params.svh
// offsets, field positions, reset values and scaling constants of the motor loop debug bank
`ifndef MLD_PARAMS_SVH
`define MLD_PARAMS_SVH

`define MLD_ADDR_W 9
`define MLD_OFS_CTRL 9'h0EE
`define MLD_OFS_GAIN 9'h0F0

`define MLD_CTRL_RESET 32'h00000000
`define MLD_GAIN_RESET 32'h00000000

`define MLD_BIT_BYPASS 26
`define MLD_VD_HI 25
`define MLD_VD_LO 16
`define MLD_VQ_HI 15
`define MLD_VQ_LO 6
`define MLD_BIT_START 5
`define MLD_BIT_RES 4
`define MLD_BIT_IND 3
`define MLD_BIT_BEMF 2
`define MLD_BIT_MECH 1
`define MLD_BIT_SHADOW 0
`define MLD_KI_LO 16
`define MLD_KP_LO 0

`define MLD_SCALE_DIV 500
`define MLD_SCALE_OFFS 1024
`define MLD_CODE_NEG_MIN 512
`define MLD_REF_ONE 16384

`endif

//--- inc/mld_pkg.sv
// types shared by the motor loop debug bank
package mld_pkg;

    typedef enum logic [1:0] {
        MLD_IDLE = 2'b01,
        MLD_RUN = 2'b10
    } mld_state_type;

    // writable content of the debug control register
    typedef struct packed {
        logic bypass;
        logic [9:0] vd;
        logic [9:0] vq;
        logic [3:0] sel;
    } mld_ctrl_type;

    // one register access from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [31:0] wdata;
    } mld_req_type;

    // measurement selection order, msb first: resistance, inductance, bemf, mechanical
    typedef logic [3:0] mld_sel_type;

endpackage

//--- bench/mld_regs_test.sv
// self-checking testbench for the motor loop debug register bank
`timescale 1ns/100ps
`include "mld_params.svh"
module mld_regs_test;
    import mld_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    mld_req_type req = '0;
    logic [31:0] rdata;
    logic rvalid;
    logic signed [15:0] ld_ref = 16'h0123;
    logic signed [15:0] lq_ref = 16'hFBAA;
    logic [9:0] ki = 10'h2A5;
    logic [9:0] kp = 10'h15A;
    logic done = 1'b0;
    logic byp, dis, mstart, mbusy, shad;
    logic signed [15:0] dref, qref;
    mld_sel_type msel;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] rd_val;
    int codes [6] = '{0, 250, 500, 513, 1000, 524};

    // free-running 20 MHz clock
    always #25 clk = ~clk;

    mld_regs mld_regs_inst (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata_ff(rdata),
        .reg_rvalid_ff(rvalid), .loop_direct_ref(ld_ref), .loop_quad_ref(lq_ref),
        .integral_gain(ki), .prop_gain(kp), .inner_loop_bypass_ff(byp), .loops_disabled_ff(dis),
        .direct_axis_voltage_ref_ff(dref), .quadrature_axis_voltage_ref_ff(qref),
        .measure_done(done), .measure_start_ff(mstart), .measure_busy_ff(mbusy),
        .measure_sel_ff(msel), .measured_to_shadow_ff(shad));

    // compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one-cycle write strobe, returns once effects are visible
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk); #1;
        req.wr = 1'b1; req.addr = a; req.wdata = d;
        @(posedge clk); #1;
        req.wr = 1'b0;
    endtask

    // one-cycle read strobe, data taken while the valid pulse stands
    task automatic rd(input logic [8:0] a);
        @(posedge clk); #1;
        req.rd = 1'b1; req.addr = a;
        @(posedge clk); #1;
        req.rd = 1'b0;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        rd_val = rdata;
        @(posedge clk); #1;
        chk("rvalid low", {31'h0, rvalid}, 32'h0);
        chk("rdata idle", rdata, 32'h0);
    endtask

    // pulse done and let busy fall
    task automatic finish_measure();
        done = 1'b1;
        @(posedge clk); #1;
        done = 1'b0;
        repeat (2) @(posedge clk); #1;
        chk("busy", {31'h0, mbusy}, 32'h0);
    endtask

    // signed reference expected from a forced code
    function automatic logic signed [15:0] scl(input int c);
        return (c <= 500) ? 16'(c * 16384 / 500) : 16'((c - 1024) * 16384 / 500);
    endfunction

    // counts and verdict
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk); #1;
        chk("bypass", {31'h0, byp}, 32'h0);
        chk("dref", dref, ld_ref);
        rd(`MLD_OFS_CTRL);
        chk("ctrl", rd_val, `MLD_CTRL_RESET);
        rd(`MLD_OFS_GAIN);
        chk("gain", rd_val, {6'h0, ki, 6'h0, kp});
        wr(`MLD_OFS_GAIN, 32'hFFFFFFFF);
        rd(`MLD_OFS_GAIN);
        chk("gain ro", rd_val, {6'h0, ki, 6'h0, kp});
        rd(9'h1FF);
        chk("unmapped", rd_val, 32'h0);
        $display("test reset and readback done");
        for (int i = 0; i < 6; i++) begin
            wr(`MLD_OFS_CTRL, {5'h1F, 1'b1, 10'(codes[i]), 10'(codes[5 - i]), 6'h00});
            chk("bypass", {31'h0, byp}, 32'h1);
            chk("loops off", {31'h0, dis}, 32'h1);
            chk("dref", dref, scl(codes[i]));
            chk("qref", qref, scl(codes[5 - i]));
            rd(`MLD_OFS_CTRL);
            chk("ctrl", rd_val, {5'h0, 1'b1, 10'(codes[i]), 10'(codes[5 - i]), 6'h00});
        end
        wr(`MLD_OFS_CTRL, 32'h0);
        chk("loops off", {31'h0, dis}, 32'h0);
        chk("qref", qref, lq_ref);
        $display("test bypass done");
        wr(`MLD_OFS_CTRL, 32'h0000003E);
        chk("start", {31'h0, mstart}, 32'h1);
        chk("busy", {31'h0, mbusy}, 32'h1);
        chk("sel", {28'h0, msel}, 32'hF);
        @(posedge clk); #1;
        chk("start", {31'h0, mstart}, 32'h0);
        rd(`MLD_OFS_CTRL);
        chk("ctrl", rd_val, 32'h0000001E);
        wr(`MLD_OFS_CTRL, 32'h00000022);
        chk("start", {31'h0, mstart}, 32'h0);
        chk("sel", {28'h0, msel}, 32'hF);
        finish_measure();
        for (int b = 0; b < 4; b++) begin
            wr(`MLD_OFS_CTRL, 32'h20 | (32'h2 << b));
            chk("start", {31'h0, mstart}, 32'h1);
            chk("sel", {28'h0, msel}, 32'h1 << b);
            finish_measure();
        end
        $display("test measurement done");
        wr(`MLD_OFS_CTRL, 32'h00000021);
        chk("shadow", {31'h0, shad}, 32'h1);
        chk("start", {31'h0, mstart}, 32'h1);
        @(posedge clk); #1;
        chk("shadow", {31'h0, shad}, 32'h0);
        wr(`MLD_OFS_CTRL, 32'h00000001);
        chk("shadow", {31'h0, shad}, 32'h1);
        finish_measure();
        $display("test shadow done");
        end_sim();
    end

    // watchdog
    initial begin
        #(3000 * 50);
        num_errors++;
        end_sim();
    end
endmodule // mld_regs_test
